// ==== core/vra_decode.sv ====
// Remaps the low vector window, decodes regions and raises access aborts.
// Assumes the core samples the answer in the cycle it drives the request.
module vra_decode
  import vra_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire vra_req_t   i_req,
  input  wire logic [1:0] i_map_mode,
  input  wire logic       i_map_wr,
  input  wire logic       i_pipe_adv,
  input  wire logic       i_pipe_flush,
  input  wire logic       i_exec,
  input  wire logic [3:0] i_ext_irq_n,
  input  wire logic [3:0] i_wake_en,
  input  wire logic       i_boot_request_port_pin,
  output vra_resp_t       o_resp,
  output logic            o_prefetch_exc,
  output logic [1:0]      o_map_mode,
  output logic [3:0]      o_ext_irq,
  output logic            o_wake,
  output logic            o_isp_request,
  output logic            o_core_start,
  output logic [31:0]     o_start_pc
);

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic slot_used(input logic [127:0] used, input logic [31:0] a);
    slot_used = used[a[VRA_SLOT_MSB:VRA_SLOT_LSB]];
  endfunction

  vra_mode_t   mode;
  logic [31:0] addr;
  logic        in_win;
  logic [31:0] win_src;
  logic [31:0] phys;
  logic        rg_flash;
  logic        rg_flash_gap;
  logic        rg_sram;
  logic        rg_sram_gap;
  logic        rg_boot;
  logic        rg_ext;
  logic        rg_pbus;
  logic        rg_ahb;
  logic        rg_bus_gap;
  logic        periph;
  logic        slot_ok;
  logic        rsvd;
  logic        abort;
  logic        pf_abort;
  vra_region_t region;
  logic [2:0]  fn_idx;
  logic        sysctl_hit;
  logic [7:0]  sysctl_sel;

  // Window source and physical address
  assign addr    = i_req.addr;
  assign in_win  = addr <= VRA_WIN_LAST;
  assign win_src = (mode == VRA_MODE_RAM)   ? VRA_SRAM_BASE :
                   (mode == VRA_MODE_FLASH) ? 32'h0000_0000 :
                                              VRA_BOOT_BASE;
  // Natural decode stays live, so remapped areas answer at both addresses
  assign phys    = in_win ? (win_src | {26'h0, addr[5:0]}) : addr;

  // Region decode on the fixed map
  assign rg_flash     = in_range(addr, 32'h0000_0000, VRA_FLASH_END - 32'h1);
  assign rg_flash_gap = in_range(addr, VRA_FLASH_END, VRA_FLASH_GAPL);
  assign rg_sram      = in_range(addr, VRA_SRAM_BASE,
                                 VRA_SRAM_BASE + VRA_SRAM_BYTES - 32'h1);
  assign rg_sram_gap  = in_range(addr, VRA_SRAM_BASE + VRA_SRAM_BYTES,
                                 VRA_SRAM_GAPL);
  assign rg_boot      = in_range(addr, VRA_BOOT_BASE, VRA_EXT_BASE - 32'h1);
  assign rg_ext       = in_range(addr, VRA_EXT_BASE, VRA_EXT_LAST);
  assign rg_pbus      = in_range(addr, VRA_PBUS_BASE, VRA_PBUS_LAST);
  assign rg_ahb       = addr >= VRA_AHB_BASE;
  assign rg_bus_gap   = in_range(addr, VRA_PBUS_LAST + 32'h1, VRA_AHB_BASE - 32'h1);

  // Slot check uses only the upper bits; offsets inside a slot are not checked
  assign slot_ok = rg_pbus ? slot_used(VRA_PBUS_USED, addr) :
                             slot_used(VRA_AHB_USED, addr);
  assign periph  = rg_pbus || rg_ahb;
  assign rsvd    = rg_flash_gap || rg_sram_gap || rg_bus_gap || (periph && !slot_ok);

  // Same-cycle answer; fetch into any peripheral space is refused
  assign pf_abort = i_req.valid && i_req.fetch && (rsvd || periph);
  assign abort    = i_req.valid && (rsvd || (i_req.fetch && periph));

  assign region = (rg_flash || in_win) ? VRA_RG_FLASH :
                  rg_sram              ? VRA_RG_SRAM  :
                  rg_boot              ? VRA_RG_BOOT  :
                  rg_ext               ? VRA_RG_EXT   :
                  (rg_pbus && slot_ok) ? VRA_RG_PBUS  :
                  (rg_ahb && slot_ok)  ? VRA_RG_AHB   :
                                         VRA_RG_NONE;

  // Control slot: one select per function group, never shared
  assign sysctl_hit = i_req.valid && !i_req.fetch && rg_pbus &&
                      (addr[VRA_SLOT_MSB:VRA_SLOT_LSB] == VRA_SYSCTL_SLOT);
  assign fn_idx     = addr[VRA_FN_LSB+2:VRA_FN_LSB];
  assign sysctl_sel = sysctl_hit ? (8'h01 << fn_idx) : 8'h00;

  assign o_resp.abort      = abort;
  assign o_resp.pf_abort   = pf_abort;
  assign o_resp.region     = region;
  assign o_resp.phys       = phys;
  assign o_resp.sysctl_sel = sysctl_sel;

  // Mapping mode: every reset returns to boot vectors
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mode <= vra_mode_t'(VRA_MODE_RESET);
    end else if (i_map_wr) begin
      mode <= (i_map_mode == VRA_MODE_RSVD) ? VRA_MODE_BOOT : vra_mode_t'(i_map_mode);
    end
  end
  assign o_map_mode = mode;

  // Abort tag rides with the fetched word; flushed words never trap
  logic tag_dec;
  logic tag_exe;
  logic next_tag_dec;
  logic next_tag_exe;
  assign next_tag_dec = i_pipe_flush ? 1'b0 : (i_pipe_adv ? pf_abort : tag_dec);
  assign next_tag_exe = i_pipe_flush ? 1'b0 : (i_pipe_adv ? tag_dec : tag_exe);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tag_dec <= 1'b0;
      tag_exe <= 1'b0;
    end else begin
      tag_dec <= next_tag_dec;
      tag_exe <= next_tag_exe;
    end
  end
  assign o_prefetch_exc = tag_exe && i_exec;

  // External interrupts, active low, also wake from idle or power-down
  logic [3:0] irq_lvl;
  logic       wake;
  assign irq_lvl = ~i_ext_irq_n;
  assign wake    = |(irq_lvl & i_wake_en);
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_ext_irq <= 4'h0;
      o_wake    <= 1'b0;
    end else begin
      o_ext_irq <= irq_lvl;
      o_wake    <= wake;
    end
  end

  // Strap caught on the first edge after release, not by the reset itself
  logic started;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      started       <= 1'b0;
      o_isp_request <= 1'b0;
      o_core_start  <= 1'b0;
      o_start_pc    <= 32'h0000_0000;
    end else begin
      started      <= 1'b1;
      o_core_start <= !started;
      o_start_pc   <= VRA_RESET_PC;
      if (!started) begin
        o_isp_request <= !i_boot_request_port_pin;
      end
    end
  end

  // Checks
  property p_win_ram;
    @(posedge i_clk_sys) disable iff (i_rst)
      (in_win && mode == VRA_MODE_RAM) |-> (phys == (VRA_SRAM_BASE | {26'h0, addr[5:0]}));
  endproperty
  a_win_ram: assert property (p_win_ram) else $error("low window not mapped to SRAM");
  property p_above_win;
    @(posedge i_clk_sys) disable iff (i_rst)
      (addr > VRA_WIN_LAST) |-> (phys == addr);
  endproperty
  a_above_win: assert property (p_above_win) else $error("fixed region moved");
  property p_flash_gap;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && addr >= VRA_FLASH_END && addr < VRA_SRAM_BASE) |-> abort;
  endproperty
  a_flash_gap: assert property (p_flash_gap) else $error("flash gap not aborted");
  property p_sram_gap;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && addr >= (VRA_SRAM_BASE + VRA_SRAM_BYTES) && addr < VRA_BOOT_BASE)
        |-> (abort && (pf_abort == i_req.fetch));
  endproperty
  a_sram_gap: assert property (p_sram_gap) else $error("sram gap not aborted");
  property p_fetch_periph;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && i_req.fetch && addr >= VRA_PBUS_BASE) |-> (pf_abort && abort);
  endproperty
  a_fetch_periph: assert property (p_fetch_periph) else $error("peripheral fetch ok");
  property p_pbus_used;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && !i_req.fetch && rg_pbus &&
       VRA_PBUS_USED[addr[VRA_SLOT_MSB:VRA_SLOT_LSB]]) |-> !abort;
  endproperty
  a_pbus_used: assert property (p_pbus_used) else $error("assigned slot aborted");
  property p_tag_carry;
    @(posedge i_clk_sys) disable iff (i_rst)
      (pf_abort && i_pipe_adv && !i_pipe_flush) ##1 (i_pipe_adv && !i_pipe_flush)
        |=> (i_exec |-> o_prefetch_exc);
  endproperty
  a_tag_carry: assert property (p_tag_carry) else $error("abort tag lost");
  property p_wake;
    @(posedge i_clk_sys) disable iff (i_rst)
      (|(~i_ext_irq_n & i_wake_en)) |=> o_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");
  property p_sysctl;
    @(posedge i_clk_sys) disable iff (i_rst)
      sysctl_hit |-> $onehot(sysctl_sel);
  endproperty
  a_sysctl: assert property (p_sysctl) else $error("control select not unique");
  property p_mode_wr;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_map_wr && i_map_mode == VRA_MODE_FLASH) |=> (o_map_mode == VRA_MODE_FLASH);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write ignored");

  // Window sources and fixed homes
  property p_win_boot;
    @(posedge i_clk_sys) disable iff (i_rst)
      (in_win && mode == VRA_MODE_BOOT) |-> (phys == (VRA_BOOT_BASE | {26'h0, addr[5:0]}));
  endproperty
  a_win_boot: assert property (p_win_boot) else $error("low window not mapped to boot block");
  property p_win_flash;
    @(posedge i_clk_sys) disable iff (i_rst)
      (in_win && mode == VRA_MODE_FLASH) |-> (phys == addr && region == VRA_RG_FLASH);
  endproperty
  a_win_flash: assert property (p_win_flash) else $error("low window not showing flash");
  property p_sram_home;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && addr >= VRA_SRAM_BASE && addr < (VRA_SRAM_BASE + VRA_SRAM_BYTES))
        |-> (!abort && region == VRA_RG_SRAM && phys == addr);
  endproperty
  a_sram_home: assert property (p_sram_home) else $error("sram lost its own address");
  property p_boot_top;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && addr >= VRA_BOOT_BASE && addr < VRA_EXT_BASE) |-> (!abort && region == VRA_RG_BOOT);
  endproperty
  a_boot_top: assert property (p_boot_top) else $error("boot block not at top");
  property p_ext_open;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && addr >= VRA_EXT_BASE && addr <= VRA_EXT_LAST) |-> (!abort && region == VRA_RG_EXT);
  endproperty
  a_ext_open: assert property (p_ext_open) else $error("external region moved or aborted");

  // Abort and control select conditions
  property p_unused_slot;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && rg_pbus && !VRA_PBUS_USED[addr[VRA_SLOT_MSB:VRA_SLOT_LSB]])
        |-> (abort && region == VRA_RG_NONE);
  endproperty
  a_unused_slot: assert property (p_unused_slot) else $error("unassigned slot not aborted");
  property p_bus_gap;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_req.valid && addr > VRA_PBUS_LAST && addr < VRA_AHB_BASE) |-> (abort && (pf_abort == i_req.fetch));
  endproperty
  a_bus_gap: assert property (p_bus_gap) else $error("bus gap not aborted");
  property p_idle_quiet;
    @(posedge i_clk_sys) disable iff (i_rst)
      !i_req.valid |-> (!abort && !pf_abort);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("abort without access");
  property p_pf_fetch;
    @(posedge i_clk_sys) disable iff (i_rst)
      pf_abort |-> (abort && i_req.fetch);
  endproperty
  a_pf_fetch: assert property (p_pf_fetch) else $error("prefetch abort on data access");
  property p_sysctl_none;
    @(posedge i_clk_sys) disable iff (i_rst)
      !sysctl_hit |-> (sysctl_sel == 8'h00);
  endproperty
  a_sysctl_none: assert property (p_sysctl_none) else $error("control select without hit");

  // Pipeline, interrupt and start-up checks
  property p_flush;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_pipe_flush |=> !o_prefetch_exc;
  endproperty
  a_flush: assert property (p_flush) else $error("flushed fetch trapped");
  property p_irq_level;
    @(posedge i_clk_sys) disable iff (i_rst)
      1'b1 |=> (o_ext_irq == ~$past(i_ext_irq_n));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level not inverted");
  property p_isp_catch;
    @(posedge i_clk_sys) disable iff (i_rst)
      !started |=> (o_isp_request == !$past(i_boot_request_port_pin));
  endproperty
  a_isp_catch: assert property (p_isp_catch) else $error("boot strap not captured");
  property p_isp_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      started |=> $stable(o_isp_request);
  endproperty
  a_isp_hold: assert property (p_isp_hold) else $error("boot strap changed after start");
  property p_start_pulse;
    @(posedge i_clk_sys) disable iff (i_rst)
      o_core_start |-> (o_start_pc == VRA_RESET_PC) ##1 !o_core_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("core start not a single pulse at zero");

endmodule

// ==== core/vra_pkg.sv ====
// Constants and carrier types for the low-vector remap and abort decode.
// Assumes one 200 MHz system clock and a core that presents one access per cycle.
// What this block does
// - Low 64 bytes, 0x00 to 0x3F, overlaid by the selected vector source.
// - A remapped area still answers at its own natural address.
// - Outside the low window every region decodes at one fixed address.
// - Boot block sits at the top of on-chip space, independent of flash size.
// - Flash end up to 0x3FFFFFFF aborts; start depends on the flash variant.
// - Gap between SRAM end and the boot block aborts; start follows SRAM size.
// - Reserved areas and unassigned peripheral slots abort fetches and data alike.
// - Any instruction fetch from either peripheral bus gets a prefetch abort.
// - Undefined offsets inside an assigned peripheral_bus slot never abort a data access.
// - Only enough bits decoded inside a peripheral; aliases unsupported.
// - Prefetch abort travels with the instruction, taken only on execution.
// - Four active-low external interrupt inputs, each able to wake the core.
// - Low boot_request_port_pin right after reset requests the programming handler.
// - Reset restores defaults; the core then starts at address zero.
// - Each system control function owns its own register addresses.
// - Each peripheral bus: 128 slots of 16 kilobytes, chosen by upper bits.
// - Reset selects boot vectors; flash mode shows flash; RAM mode shows SRAM.
package vra_pkg;
  localparam logic [31:0] VRA_WIN_LAST   = 32'h0000_003f;
  localparam logic [31:0] VRA_FLASH_32K  = 32'h0000_8000;
  localparam logic [31:0] VRA_FLASH_64K  = 32'h0001_0000;
  localparam logic [31:0] VRA_FLASH_512K = 32'h0008_0000;
  localparam logic [31:0] VRA_FLASH_END  = VRA_FLASH_512K;
  localparam logic [31:0] VRA_FLASH_GAPL = 32'h3fff_ffff;
  localparam logic [31:0] VRA_SRAM_BASE  = 32'h4000_0000;
  localparam logic [31:0] VRA_SRAM_BYTES = 32'h0000_8000;
  localparam logic [31:0] VRA_SRAM_GAPL  = 32'h7fff_dfff;
  localparam logic [31:0] VRA_BOOT_BASE  = 32'h7fff_e000;
  localparam logic [31:0] VRA_EXT_BASE   = 32'h8000_0000;
  localparam logic [31:0] VRA_EXT_LAST   = 32'hdfff_ffff;
  localparam logic [31:0] VRA_PBUS_BASE  = 32'he000_0000;
  localparam logic [31:0] VRA_PBUS_LAST  = 32'he01f_ffff;
  localparam logic [31:0] VRA_AHB_BASE   = 32'hffe0_0000;
  localparam logic [31:0] VRA_RESET_PC   = 32'h0000_0000;
  localparam int          VRA_SLOT_LSB   = 14;
  localparam int          VRA_SLOT_MSB   = 20;
  localparam int          VRA_FN_LSB     = 6;
  localparam logic [6:0]  VRA_SYSCTL_SLOT = 7'h7f;
  // Assigned peripheral_bus slots: 0-5, 7-11, 13, 23, 24, 26, 27, 127
  localparam logic [127:0] VRA_PBUS_USED = 128'h8000_0000_0000_0000_0000_0000_0d80_2fbf;
  localparam logic [127:0] VRA_AHB_USED  = 128'h8000_0000_0000_0000_0000_0000_0000_0000;
  localparam logic [1:0]  VRA_MODE_RESET = 2'h0;

  typedef enum logic [1:0] {
    VRA_MODE_BOOT  = 2'b00,
    VRA_MODE_FLASH = 2'b01,
    VRA_MODE_RAM   = 2'b10,
    VRA_MODE_RSVD  = 2'b11
  } vra_mode_t;

  typedef enum logic [2:0] {
    VRA_RG_FLASH = 3'b000,
    VRA_RG_SRAM  = 3'b001,
    VRA_RG_BOOT  = 3'b010,
    VRA_RG_EXT   = 3'b011,
    VRA_RG_PBUS  = 3'b100,
    VRA_RG_AHB   = 3'b101,
    VRA_RG_NONE  = 3'b110
  } vra_region_t;

  typedef struct packed {
    logic        valid;
    logic        fetch;
    logic [31:0] addr;
  } vra_req_t;

  typedef struct packed {
    logic        abort;
    logic        pf_abort;
    vra_region_t region;
    logic [31:0] phys;
    logic [7:0]  sysctl_sel;
  } vra_resp_t;
endpackage

// ==== verification/vra_core_model.sv ====
// Processor-side model: presents one access a cycle and drives the pipeline controls.
// Assumes the bench calls its tasks and that every input changes at the falling edge.
module vra_core_model
  import vra_pkg::*;
(
  input  wire logic i_clk_sys,
  output vra_req_t  o_req,
  output logic      o_pipe_adv,
  output logic      o_pipe_flush,
  output logic      o_exec
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_req = '0;
    o_pipe_adv = 1'b0;
    o_pipe_flush = 1'b0;
    o_exec = 1'b0;
  end
  task automatic issue(input logic [31:0] a, input logic f, input logic adv, input logic fl, input logic ex);
    @(negedge i_clk_sys);
    o_req <= '{valid: 1'b1, fetch: f, addr: a};
    o_pipe_adv <= adv;
    o_pipe_flush <= fl;
    o_exec <= ex;
  endtask
  // Idle bus shows a toggling address so stale values are never trusted
  task automatic idle();
    @(negedge i_clk_sys);
    o_req <= '{valid: 1'b0, fetch: ~o_req.fetch, addr: ~o_req.addr};
    o_pipe_adv <= 1'b0;
    o_exec <= 1'b0;
    o_pipe_flush <= 1'b0;
  endtask
endmodule

// ==== verification/vra_decode_tb.sv ====
// Self-checking bench for the low-vector remap and abort decode.
// Assumes the core model drives accesses; expectations come from the memory map.
module vra_decode_tb
  import vra_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] map_mode = 2'h0;
  logic map_wr = 1'b0;
  logic [3:0] irq_n = 4'hf;
  logic [3:0] wake_en = 4'h0;
  logic boot_pin = 1'b1;
  vra_req_t req;
  logic adv, flush, exec;
  vra_resp_t resp;
  logic exc, wake, isp, cstart;
  logic [1:0] mode_out;
  logic [3:0] irq;
  logic [31:0] start_pc;
  logic [1:0] mode_exp = 2'h0;
  logic [31:0] seed = 32'h0f9a9d86;
  int n_mismatch = 0;
  int total_checks = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  vra_core_model core (.i_clk_sys(i_clk_sys), .o_req(req), .o_pipe_adv(adv), .o_pipe_flush(flush), .o_exec(exec));
  vra_decode dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(req), .i_map_mode(map_mode), .i_map_wr(map_wr),
    .i_pipe_adv(adv), .i_pipe_flush(flush), .i_exec(exec), .i_ext_irq_n(irq_n), .i_wake_en(wake_en),
    .i_boot_request_port_pin(boot_pin), .o_resp(resp), .o_prefetch_exc(exc), .o_map_mode(mode_out),
    .o_ext_irq(irq), .o_wake(wake), .o_isp_request(isp), .o_core_start(cstart), .o_start_pc(start_pc));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic vra_resp_t expect_resp(logic [31:0] a, logic f, logic [1:0] m);
    vra_resp_t r;
    r = '0;
    r.phys = a;
    r.region = VRA_RG_NONE;
    r.abort = 1'b1;
    if (a <= VRA_WIN_LAST) begin
      r.region = VRA_RG_FLASH;
      r.phys = (m == 2'h1) ? a : (m == 2'h2) ? VRA_SRAM_BASE + a : VRA_BOOT_BASE + a;
    end else if (a < VRA_FLASH_END) r.region = VRA_RG_FLASH;
    else if (a >= VRA_SRAM_BASE && a < VRA_SRAM_BASE + VRA_SRAM_BYTES) r.region = VRA_RG_SRAM;
    else if (a >= VRA_BOOT_BASE && a < VRA_EXT_BASE) r.region = VRA_RG_BOOT;
    else if (a >= VRA_EXT_BASE && a <= VRA_EXT_LAST) r.region = VRA_RG_EXT;
    else if (a >= VRA_PBUS_BASE && a <= VRA_PBUS_LAST) r.region = VRA_PBUS_USED[a[20:14]] ? VRA_RG_PBUS : VRA_RG_NONE;
    else if (a >= VRA_AHB_BASE) r.region = VRA_AHB_USED[a[20:14]] ? VRA_RG_AHB : VRA_RG_NONE;
    r.abort = (r.region == VRA_RG_NONE) | (f & (r.region inside {VRA_RG_PBUS, VRA_RG_AHB}));
    if (r.region == VRA_RG_PBUS && a[20:14] == VRA_SYSCTL_SLOT && !f) r.sysctl_sel = 8'h01 << a[8:6];
    r.pf_abort = r.abort & f;
    return r;
  endfunction
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic access_check(input logic [31:0] a, input logic f);
    vra_resp_t e;
    core.issue(a, f, 1'b0, 1'b0, 1'b0);
    #2;
    e = expect_resp(a, f, mode_exp);
    chk("abort", e.abort, resp.abort);
    chk("pf_abort", e.pf_abort, resp.pf_abort);
    chk("phys", e.phys, resp.phys);
    chk("region", e.region, resp.region);
    chk("sysctl_sel", e.sysctl_sel, resp.sysctl_sel);
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(negedge i_clk_sys);
    map_mode <= m;
    map_wr <= 1'b1;
    @(negedge i_clk_sys);
    map_wr <= 1'b0;
    mode_exp = (m == 2'h3) ? 2'h0 : m;
    chk("map_mode", mode_exp, mode_out);
    access_check(32'h0000_0010, 1'b0);
  endtask
  task automatic do_reset(input logic pin);
    @(negedge i_clk_sys);
    i_rst <= 1'b1;
    boot_pin <= pin;
    repeat (6) @(negedge i_clk_sys);
    i_rst <= 1'b0;
    mode_exp = 2'h0;
    chk("map_mode", 2'h0, mode_out);
    @(negedge i_clk_sys);
    chk("core_start", 1'b1, cstart);
    chk("isp_request", !pin, isp);
    @(negedge i_clk_sys);
    chk("core_start", 1'b0, cstart);
    chk("start_pc", VRA_RESET_PC, start_pc);
    @(negedge i_clk_sys);
    chk("core_start", 1'b0, cstart);
    access_check(32'h0000_003c, 1'b1);
    $display("reset test done");
  endtask
  initial begin
    logic [31:0] r, a;
    logic [31:0] bases [8] = '{32'h0, 32'h0007_ff00, 32'h3fff_ff00, 32'h4000_7f00, 32'h7fff_df00,
      32'h8000_0000, 32'he000_0000, 32'hffe0_0000};
    logic [31:0] corners [12] = '{32'h3f, 32'h40, 32'h7_fffc, 32'h8_0000, 32'h3fff_fffc, 32'h4000_8000,
      32'h7fff_e000, 32'he001_8000, 32'he000_d000, 32'he01f_c040, 32'he020_0000, 32'hfffc_0000};
    do_reset(1'b0);
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      foreach (corners[i]) access_check(corners[i], m[0]);
    end
    $display("corner test done");
    for (int i = 0; i < 300; i++) begin
      r = xs();
      a = bases[r[2:0]] + (xs() & ((r[2] & r[1]) ? 32'h001f_fffc : 32'h0000_01fc));
      if (r[7:4] == 4'h0) set_mode(r[9:8]);
      access_check(a, r[3]);
    end
    $display("random access test done");
    core.issue(32'he000_0000, 1'b1, 1'b1, 1'b0, 1'b0);
    core.issue(32'h0000_0100, 1'b1, 1'b1, 1'b0, 1'b0);
    core.issue(32'h0000_0104, 1'b1, 1'b0, 1'b0, 1'b1);
    #2 chk("prefetch_exc", 1'b1, exc);
    core.issue(32'hffe0_0000, 1'b1, 1'b1, 1'b0, 1'b0);
    core.issue(32'h0000_0100, 1'b1, 1'b1, 1'b0, 1'b0);
    core.issue(32'h0000_0104, 1'b1, 1'b0, 1'b1, 1'b0);
    #2 chk("prefetch_exc", 1'b0, exc);
    core.issue(32'h0000_0108, 1'b1, 1'b0, 1'b0, 1'b1);
    #2 chk("prefetch_exc", 1'b0, exc);
    core.idle();
    $display("prefetch abort test done");
    for (int i = 0; i < 24; i++) begin
      r = xs();
      @(negedge i_clk_sys);
      irq_n <= r[3:0];
      wake_en <= r[7:4];
      @(negedge i_clk_sys);
      chk("ext_irq", 4'(~r[3:0]), irq);
      chk("wake", |(~r[3:0] & r[7:4]), wake);
    end
    $display("interrupt test done");
    set_mode(2'h2);
    do_reset(1'b1);
    results();
  end
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    results();
  end
endmodule
